/* File: core/aps_top.sv */
// Actuator position supervisor: APB settings, range and end-zone watch,
// home direction, profile choice, stop control and radio gating.
// Assumes position and deviation inputs arrive from logic on clk.
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module aps_top #(
  parameter logic [19:0] STROKE_MAX = 20'h04e20,
  parameter logic [19:0] HOME_OFS_RST = 20'h00032,
  parameter logic HOME_DIR_RST = 1'b0,
  parameter logic [15:0] SCREW_LEAD = 16'h03e8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Position feedback, 0.01 mm from home-side stop, and pulse deviation
  input wire logic signed [23:0] pos_in,
  input wire logic signed [15:0] pos_dev,
  input wire logic in_motion,
  input wire logic home_done,
  // Supervision outputs
  output logic [1:0] end_zone_signal,
  output logic range_fault,
  output logic rehome_req,
  // Drive settings
  output logic dir_invert,
  output logic profile_s,
  output logic correct_en,
  output logic load_cur_mode,
  // Radio gating
  output logic radio_tx_en,
  output logic radio_rx_en
);
  import aps_pkg::*;

  logic [19:0] range_reg;
  logic [19:0] zone_reg;
  logic [19:0] home_reg;
  logic [3:0] ctrl_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic bwd_reg;
  logic fwd_reg;
  logic over_reg;
  logic rehome_reg;
  logic rehome_next;
  logic [3:0] ctrl_rst;

  // Bus decode.
  wire logic acc_first;
  wire logic wr_fire;
  wire logic hit_range;
  wire logic hit_zone;
  wire logic hit_home;
  wire logic hit_ctrl;
  wire logic hit_stat;
  wire logic mapped;
  wire logic hi_zero;
  wire logic [19:0] wval;
  wire logic [29:0] res_prod;
  wire logic too_fine;
  wire logic nz;
  wire logic range_ok;
  wire logic zone_ok;
  wire logic home_ok;
  wire logic wr_err;
  wire logic [31:0] rd_mux;
  wire logic [5:0] stat_word;

  assign acc_first = psel & penable & ~pready_reg;
  assign wr_fire = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign hit_range = paddr == APS_OFS_RANGE;
  assign hit_zone = paddr == APS_OFS_ZONE;
  assign hit_home = paddr == APS_OFS_HOME;
  assign hit_ctrl = paddr == APS_OFS_CTRL;
  assign hit_stat = paddr == APS_OFS_STAT;
  assign mapped = hit_range | hit_zone | hit_home | hit_ctrl | hit_stat;
  assign hi_zero = pwdata[31:20] == 12'h000;
  assign wval = pwdata[19:0];
  assign nz = wval != 20'h00000;
  // Finest settable step is one encoder pulse of travel.
  assign res_prod = 30'(wval) * 30'(APS_PULSE_REV);
  assign too_fine = res_prod < 30'(SCREW_LEAD);
  assign range_ok = hi_zero & (wval <= APS_RANGE_MAX)
    & ~(nz & too_fine);
  assign zone_ok = hi_zero & (wval <= APS_DIST_MAX) & ~too_fine;
  assign home_ok = hi_zero & (wval <= APS_DIST_MAX)
    & ~(nz & too_fine);
  // Refused values leave the register untouched and answer with an error.
  assign wr_err = ~mapped | (pwrite & (hit_stat
    | (hit_range & ~range_ok) | (hit_zone & ~zone_ok)
    | (hit_home & ~home_ok)));

  assign stat_word = {load_cur_mode, correct_en, rehome_reg, over_reg,
    fwd_reg, bwd_reg};
  assign rd_mux = hit_range ? {12'h000, range_reg} :
    hit_zone ? {12'h000, zone_reg} :
    hit_home ? {12'h000, home_reg} :
    hit_ctrl ? {28'h0000000, ctrl_reg} :
    hit_stat ? {26'h0000000, stat_word} : 32'h00000000;

  // One wait state keeps read data coming straight from a flop.
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= acc_first;
      pslverr_reg <= acc_first & wr_err;
      prdata_reg <= (acc_first & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // Settings registers.
  assign ctrl_rst = {APS_RADIO_RST, APS_STOPCUR_RST, APS_SMOOTH_RST,
    HOME_DIR_RST};

  always_ff @(posedge clk) begin
    if (rst) begin
      range_reg <= STROKE_MAX;
      zone_reg <= APS_ZONE_RST;
      home_reg <= HOME_OFS_RST;
      ctrl_reg <= ctrl_rst;
    end else if (wr_fire) begin
      if (hit_range) begin
        range_reg <= wval;
      end
      if (hit_zone) begin
        zone_reg <= wval;
      end
      if (hit_home) begin
        home_reg <= wval;
      end
      if (hit_ctrl) begin
        ctrl_reg <= pwdata[3:0];
      end
    end
  end

  // Position relative to home; every limit below is taken from there.
  wire logic signed [24:0] rel_pos;
  wire logic signed [24:0] lim_pos;
  wire logic signed [24:0] fwd_edge;
  wire logic signed [24:0] bwd_edge;
  wire logic in_bwd;
  wire logic in_fwd;
  wire logic over;

  assign rel_pos = $signed({pos_in[23], pos_in})
    - $signed({5'h00, home_reg});
  assign lim_pos = $signed({5'h00, range_reg})
    + $signed({5'h00, APS_MARGIN});
  assign bwd_edge = $signed({5'h00, zone_reg});
  assign fwd_edge = $signed({5'h00, range_reg})
    - $signed({5'h00, zone_reg});
  assign in_bwd = rel_pos <= bwd_edge;
  assign in_fwd = rel_pos >= fwd_edge;
  assign over = rel_pos > lim_pos;

  always_ff @(posedge clk) begin
    if (rst) begin
      bwd_reg <= 1'b0;
      fwd_reg <= 1'b0;
      over_reg <= 1'b0;
    end else begin
      bwd_reg <= in_bwd;
      fwd_reg <= in_fwd;
      over_reg <= over;
    end
  end

  assign end_zone_signal = {fwd_reg, bwd_reg};
  assign range_fault = over_reg;

  // Home reference is stale after a direction or offset change; a new
  // change in the same cycle as home_done wins over the clear.
  wire logic dir_change;
  wire logic home_change;
  assign dir_change = wr_fire & hit_ctrl
    & (pwdata[APS_CTRL_DIR] != ctrl_reg[APS_CTRL_DIR]);
  assign home_change = wr_fire & hit_home & (wval != home_reg);
  assign rehome_next = (dir_change | home_change) ? 1'b1 :
    home_done ? 1'b0 : rehome_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      rehome_reg <= 1'b0;
    end else begin
      rehome_reg <= rehome_next;
    end
  end

  assign rehome_req = rehome_reg;
  assign dir_invert = ctrl_reg[APS_CTRL_DIR] ^ HOME_DIR_RST;
  assign profile_s = ctrl_reg[APS_CTRL_SMOOTH];
  assign radio_tx_en = ctrl_reg[APS_CTRL_RADIO];
  assign radio_rx_en = ctrl_reg[APS_CTRL_RADIO];

  aps_stop_ctl u_stop (
    .clk(clk),
    .rst(rst),
    .stop_cur_en(ctrl_reg[APS_CTRL_STOPCUR]),
    .in_motion(in_motion),
    .pos_dev(pos_dev),
    .correct_en(correct_en),
    .load_cur_mode(load_cur_mode)
  );

  property p_over;
    @(posedge clk) disable iff (rst)
      (rel_pos > $signed({5'h00, range_reg}) + 30) |=> range_fault;
  endproperty
  a_over: assert property (p_over)
    else $error("Travel past range plus margin not flagged.");

  property p_range_cap;
    @(posedge clk) disable iff (rst)
      (wr_fire && hit_range) |-> (wval <= 999969);
  endproperty
  a_range_cap: assert property (p_range_cap)
    else $error("Range accepted above its ceiling.");

  property p_bwd_on;
    @(posedge clk) disable iff (rst)
      (!rst && rel_pos <= $signed({5'h00, zone_reg})) |=> end_zone_signal[0];
  endproperty
  a_bwd_on: assert property (p_bwd_on)
    else $error("Backward end missing inside its window.");

  property p_fwd_off;
    @(posedge clk) disable iff (rst)
      (!in_fwd ##1 !$past(in_fwd)) |-> !end_zone_signal[1];
  endproperty
  a_fwd_off: assert property (p_fwd_off)
    else $error("Forward end held after leaving its window.");

  property p_fine;
    @(posedge clk) disable iff (rst)
      (acc_first && pwrite && hit_zone && too_fine)
        |=> pslverr ##1 $stable(zone_reg);
  endproperty
  a_fine: assert property (p_fine)
    else $error("Window finer than one pulse was taken.");

  property p_home_cap;
    @(posedge clk) disable iff (rst)
      (acc_first && pwrite && hit_home && !hi_zero)
        |=> pslverr ##1 $stable(home_reg);
  endproperty
  a_home_cap: assert property (p_home_cap)
    else $error("Home offset accepted beyond its ceiling.");

  property p_dir_flip;
    @(posedge clk) disable iff (rst)
      dir_change |=> (dir_invert != $past(dir_invert)) && rehome_req;
  endproperty
  a_dir_flip: assert property (p_dir_flip)
    else $error("Direction change did not reverse moves.");

  property p_radio_off;
    @(posedge clk) disable iff (rst)
      (wr_fire && hit_ctrl && !pwdata[APS_CTRL_RADIO])
        |=> !radio_tx_en && !radio_rx_en;
  endproperty
  a_radio_off: assert property (p_radio_off)
    else $error("Radio left active after being disabled.");

  property p_profile;
    @(posedge clk) disable iff (rst)
      (wr_fire && hit_ctrl) |=> profile_s == $past(pwdata[APS_CTRL_SMOOTH]);
  endproperty
  a_profile: assert property (p_profile)
    else $error("Profile choice does not follow the smooth bit.");

endmodule // aps_top

`default_nettype wire

/* File: core/aps_pkg.sv */
// Package for the actuator position supervisor: register map, field
// positions, reset values and the fixed figures of the supervision logic.
// Assumes distances in units of 0.01 mm and deviations in encoder pulses.
package aps_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] APS_OFS_RANGE = 8'h00;
  localparam logic [7:0] APS_OFS_ZONE = 8'h04;
  localparam logic [7:0] APS_OFS_HOME = 8'h08;
  localparam logic [7:0] APS_OFS_CTRL = 8'h0c;
  localparam logic [7:0] APS_OFS_STAT = 8'h10;

  // Control register fields.
  localparam int APS_CTRL_DIR = 0;
  localparam int APS_CTRL_SMOOTH = 1;
  localparam int APS_CTRL_STOPCUR = 2;
  localparam int APS_CTRL_RADIO = 3;

  // Status register fields.
  localparam int APS_ST_BWD = 0;
  localparam int APS_ST_FWD = 1;
  localparam int APS_ST_OVER = 2;
  localparam int APS_ST_REHOME = 3;
  localparam int APS_ST_CORR = 4;
  localparam int APS_ST_LOADCUR = 5;

  // Distance width in bits, then distances, all in 0.01 mm steps.
  localparam int APS_DW = 20;
  localparam logic [19:0] APS_MARGIN = 20'h0001e;
  localparam logic [19:0] APS_RANGE_MAX = 20'hf4221;
  localparam logic [19:0] APS_DIST_MAX = 20'hf423f;
  localparam logic [19:0] APS_ZONE_RST = 20'h0000a;

  // Encoder pulses per screw revolution, and stop deviation thresholds.
  localparam logic [9:0] APS_PULSE_REV = 10'h320;
  localparam logic [15:0] APS_DEV_HOLD = 16'h0002;
  localparam logic [15:0] APS_DEV_GO = 16'h0001;

  // Control reset values other than the direction bit.
  localparam logic APS_SMOOTH_RST = 1'b0;
  localparam logic APS_STOPCUR_RST = 1'b0;
  localparam logic APS_RADIO_RST = 1'b1;

endpackage

/* File: core/aps_stop_ctl.sv */
// Stop behaviour of the actuator: holding current mode and whether the
// position loop still corrects the remaining deviation.
// Assumes pos_dev and in_motion come from motor logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module aps_stop_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Settings and feedback
  input wire logic stop_cur_en,
  input wire logic in_motion,
  input wire logic signed [15:0] pos_dev,
  // Decisions
  output logic correct_en,
  output logic load_cur_mode
);
  import aps_pkg::*;

  logic correct_reg;
  logic correct_next;
  logic load_cur_reg;
  logic load_cur_next;
  wire logic [15:0] dev_mag;
  wire logic need_hold;
  wire logic need_go;

  // The most negative deviation wraps to itself, which still reads large.
  assign dev_mag = pos_dev[15] ? 16'(-pos_dev) : 16'(pos_dev);
  assign need_hold = dev_mag > APS_DEV_HOLD;
  assign need_go = dev_mag >= APS_DEV_GO;
  assign correct_next = stop_cur_en ? need_go : need_hold;
  // Load-dependent current only at rest with stop control on; constant current otherwise.
  assign load_cur_next = stop_cur_en & ~in_motion;

  always_ff @(posedge clk) begin
    if (rst) begin
      correct_reg <= 1'b0;
      load_cur_reg <= 1'b0;
    end else begin
      correct_reg <= correct_next;
      load_cur_reg <= load_cur_next;
    end
  end

  assign correct_en = correct_reg;
  assign load_cur_mode = load_cur_reg;

  property p_hold_band;
    @(posedge clk) disable iff (rst)
      (!stop_cur_en && pos_dev <= 2 && pos_dev >= -2) |=> !correct_en;
  endproperty
  a_hold_band: assert property (p_hold_band)
    else $error("Correction kept inside the two pulse band.");

  property p_go_band;
    @(posedge clk) disable iff (rst)
      (stop_cur_en && pos_dev != 0) |=> correct_en;
  endproperty
  a_go_band: assert property (p_go_band)
    else $error("Correction stopped with a pulse of deviation left.");

  property p_const_cur;
    @(posedge clk) disable iff (rst)
      (!stop_cur_en ##1 !stop_cur_en) |-> !load_cur_mode;
  endproperty
  a_const_cur: assert property (p_const_cur)
    else $error("Load current chosen while stop control is off.");

  property p_load_cur;
    @(posedge clk) disable iff (rst)
      (stop_cur_en && !in_motion) |=> load_cur_mode;
  endproperty
  a_load_cur: assert property (p_load_cur)
    else $error("Load current missing at rest with stop control on.");

endmodule // aps_stop_ctl

`default_nettype wire

/* File: testbench/aps_drive_model.sv */
// Behavioural motor drive and position feedback facing the supervisor.
// Assumes the bench commands position, deviation and motion on clk.
`timescale 1ns/100ps
`default_nettype none

module aps_drive_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Commands from the bench
  input wire logic [23:0] pos_cmd,
  input wire logic [15:0] dev_cmd,
  input wire logic mov_cmd,
  input wire logic home_cmd,
  // Feedback to the supervisor
  output logic signed [23:0] pos_in,
  output logic signed [15:0] pos_dev,
  output logic in_motion,
  output logic home_done
);
  // Feedback lags the command by one edge, as a real encoder path would.
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_in <= 24'h000000;
      pos_dev <= 16'h0000;
      in_motion <= 1'b0;
      home_done <= 1'b0;
    end else begin
      pos_in <= pos_cmd;
      pos_dev <= dev_cmd;
      in_motion <= mov_cmd;
      home_done <= home_cmd;
    end
  end
endmodule // aps_drive_model

`default_nettype wire

/* File: testbench/testbench.sv */
// Self-checking bench: APB master, table of position cases, then register
// refusals, home, control and map checks.
// Assumes aps_top with default parameters and the drive model beside it.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import aps_pkg::*;
  typedef struct packed {
    logic [3:0] ctrl;
    logic [23:0] pos;
    logic [15:0] dev;
    logic mov;
    logic [4:0] ex;
  } aps_row_t;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic e;
    logic [31:0] rb;
  } aps_wr_t;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] pos_cmd;
  logic [15:0] dev_cmd;
  logic mov_cmd, home_cmd, in_motion, home_done, range_fault, rehome_req;
  logic signed [23:0] pos_in;
  logic signed [15:0] pos_dev;
  logic [1:0] end_zone_signal;
  logic dir_invert, profile_s, correct_en, load_cur_mode;
  logic radio_tx_en, radio_rx_en;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] rstv [4] = '{32'h4e20, 32'ha, 32'h32, 32'h8};
  logic [3:0] cv [4] = '{4'h9, 4'ha, 4'h0, 4'h8};
  // Expectation bits: end zone (2), over range, correcting, load current.
  aps_row_t rows [11] = '{
    {4'h8, 24'h32, 16'h0, 1'b0, 5'b01000},
    {4'h8, 24'h3c, 16'h2, 1'b0, 5'b01000},
    {4'h8, 24'h3d, 16'h3, 1'b0, 5'b00010},
    {4'h8, 24'h4e47, 16'hfffd, 1'b0, 5'b00010},
    {4'h8, 24'h4e48, 16'h0, 1'b1, 5'b10000},
    {4'h8, 24'h4e70, 16'h0, 1'b0, 5'b10000},
    {4'h8, 24'h4e71, 16'h0, 1'b0, 5'b10100},
    {4'hc, 24'h3e8, 16'h1, 1'b0, 5'b00011},
    {4'hc, 24'h3e8, 16'hffff, 1'b1, 5'b00010},
    {4'hc, 24'h3e8, 16'h0, 1'b0, 5'b00001},
    {4'h8, 24'ha, 16'hfffe, 1'b0, 5'b01000}};
  // Home offsets written stay at or above the reset value.
  aps_wr_t wr [17] = '{
    {8'h00, 32'hf4222, 1'b1, 32'h4e20}, {8'h00, 32'hf4221, 1'b0, 32'hf4221},
    {8'h00, 32'h1, 1'b1, 32'hf4221}, {8'h00, 32'h0, 1'b0, 32'h0},
    {8'h00, 32'h100000, 1'b1, 32'h0}, {8'h04, 32'h0, 1'b1, 32'ha},
    {8'h04, 32'h1, 1'b1, 32'ha}, {8'h04, 32'h2, 1'b0, 32'h2},
    {8'h04, 32'hf4240, 1'b1, 32'h2}, {8'h04, 32'hf423f, 1'b0, 32'hf423f},
    {8'h08, 32'hf4240, 1'b1, 32'h32}, {8'h08, 32'hf423f, 1'b0, 32'hf423f},
    {8'h08, 32'h100032, 1'b1, 32'hf423f},
    {8'h00, 32'h4e20, 1'b0, 32'h4e20}, {8'h04, 32'ha, 1'b0, 32'ha},
    {8'h08, 32'h32, 1'b0, 32'h32}, {8'h0c, 32'h8, 1'b0, 32'h8}};

  aps_top u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pos_in(pos_in), .pos_dev(pos_dev),
    .in_motion(in_motion), .home_done(home_done),
    .end_zone_signal(end_zone_signal), .range_fault(range_fault),
    .rehome_req(rehome_req), .dir_invert(dir_invert),
    .profile_s(profile_s), .correct_en(correct_en),
    .load_cur_mode(load_cur_mode), .radio_tx_en(radio_tx_en),
    .radio_rx_en(radio_rx_en));
  aps_drive_model u_drv (.clk(clk), .rst(rst), .pos_cmd(pos_cmd),
    .dev_cmd(dev_cmd), .mov_cmd(mov_cmd), .home_cmd(home_cmd),
    .pos_in(pos_in), .pos_dev(pos_dev), .in_motion(in_motion),
    .home_done(home_done));

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      $display("wrong value %s expected %h seen %h", nm, ex, got);
      err_total++;
    end
  endtask

  // The request holds until pready is seen at an edge; the slave's wait
  // state count is never assumed.
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #300000;
    err_total++;
    end_sim();
  end

  initial begin
    rst <= 1'b1;
    {psel, penable, pwrite, mov_cmd, home_cmd} <= 5'h0;
    paddr <= 8'h0;
    pwdata <= 32'h0;
    pos_cmd <= 24'h0;
    dev_cmd <= 16'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("radio", 32'h3, {radio_tx_en, radio_rx_en});
    for (int i = 0; i < 4; i++) begin
      apb(8'(4 * i), 1'b0, 32'h0, rd, er);
      chk("reset reg", rstv[i], rd);
    end
    foreach (rows[i]) begin
      apb(APS_OFS_CTRL, 1'b1, {28'h0, rows[i].ctrl}, rd, er);
      pos_cmd <= rows[i].pos;
      dev_cmd <= rows[i].dev;
      mov_cmd <= rows[i].mov;
      repeat (3) @(posedge clk);
      chk("end zone", rows[i].ex[4:3], end_zone_signal);
      chk("range", rows[i].ex[2], range_fault);
      chk("correct", rows[i].ex[1], correct_en);
      chk("stop cur", rows[i].ex[0], load_cur_mode);
    end
    foreach (wr[i]) begin
      apb(wr[i].a, 1'b1, wr[i].d, rd, er);
      chk("refusal", {31'h0, wr[i].e}, {31'h0, er});
      apb(wr[i].a, 1'b0, 32'h0, rd, er);
      chk("readback", wr[i].rb, rd);
    end
    chk("rehome set", 32'h1, rehome_req);
    home_cmd <= 1'b1;
    @(posedge clk);
    home_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rehome clr", 32'h0, rehome_req);
    // Smoothing is only turned on by the second control value, 4'ha, in this bench.
    foreach (cv[i]) begin
      apb(APS_OFS_CTRL, 1'b1, {28'h0, cv[i]}, rd, er);
      @(posedge clk);
      chk("dir", cv[i][0], dir_invert);
      chk("profile", cv[i][1], profile_s);
      chk("radio", {2{cv[i][3]}}, {radio_tx_en, radio_rx_en});
      chk("rehome dir", 32'h1, rehome_req);
    end
    apb(APS_OFS_HOME, 1'b1, 32'h3c, rd, er);
    for (int k = 0; k < 2; k++) begin
      pos_cmd <= 24'h4e7a + 24'(k);
      repeat (3) @(posedge clk);
      chk("range home", 32'(k), range_fault);
    end
    // Forward end, over range and a stale home reference all stand here.
    apb(APS_OFS_STAT, 1'b0, 32'h0, rd, er);
    chk("status", 32'he, rd);
    apb(8'h14, 1'b0, 32'h0, rd, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    apb(APS_OFS_STAT, 1'b1, 32'h3f, rd, er);
    chk("stat write", 32'h1, er);
    end_sim();
  end
endmodule // testbench

`default_nettype wire
